// ===== src/irq_vec_pkg.sv
// interrupt source constants, vector table and default priorities
// Function
// - operand check failure traps via 003CH
// - break instruction traps unmaskably via 003EH
// - pin edges: nonmaskable 0002H, pins 4/5
// - watchdog overflow nonmaskable via 0004H
// - pin0 edge priority 0, timer1 trigger
// - pins 1,2 priorities 1,2, timer2 trigger
// - pin3 priority 3, timer0 trigger
// - timer0 matches priorities 4,5
// - timer1 match source follows counter mode
// - timer2 priorities 8,9; timer3 priority 10
// - conversion done priority 13 via 0020H
// - async0 receive error priority 14
// - async0 rx and clocked done share 15
// - async0 tx 0026H, clocked serial 0028H
// - async2 error, rx/clocked2, tx requests
// - bus stop condition lowest, priority 21
// - accepted vector entry loads program counter
// - entry pushes program counter and status
// - return restores status and program counter bits 15:0, bits 19:16 cleared
// - branch target limited to 16 bits
package irq_vec_pkg;
    localparam int          NUM_MASKABLE   = 22;
    localparam int          PC_W           = 20;
    localparam int          ADDR_W         = 16;
    localparam logic [7:0]  OPERAND_OK     = 8'hFF;
    localparam logic [15:0] VEC_OPERR      = 16'h003C;
    localparam logic [15:0] VEC_BREAK      = 16'h003E;
    localparam logic [15:0] VEC_PIN_NMI    = 16'h0002;
    localparam logic [15:0] VEC_WATCHDOG   = 16'h0004;
    localparam logic [15:0] VEC_MASK_BASE  = 16'h0006;
    localparam logic [15:0] VEC_STEP       = 16'h0002;
    localparam logic [3:0]  PC_TOP_CLEAR   = 4'h0;

    // default priority numbers = bit index of the maskable request vector
    localparam int PRI_PIN0   = 0;
    localparam int PRI_PIN1   = 1;
    localparam int PRI_PIN2   = 2;
    localparam int PRI_PIN3   = 3;
    localparam int PRI_T0A    = 4;
    localparam int PRI_T0B    = 5;
    localparam int PRI_T1A    = 6;
    localparam int PRI_T1B    = 7;
    localparam int PRI_T2A    = 8;
    localparam int PRI_T2B    = 9;
    localparam int PRI_T3     = 10;
    localparam int PRI_PIN4   = 11;
    localparam int PRI_PIN5   = 12;
    localparam int PRI_CONV   = 13;
    localparam int PRI_A0ERR  = 14;
    localparam int PRI_A0RX   = 15;
    localparam int PRI_A0TX   = 16;
    localparam int PRI_CSI    = 17;
    localparam int PRI_A2ERR  = 18;
    localparam int PRI_A2RX   = 19;
    localparam int PRI_A2TX   = 20;
    localparam int PRI_I2C    = 21;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_SOFT,
        SRC_NMI,
        SRC_MASK
    } src_kind_t;
endpackage : irq_vec_pkg

// ===== src/irq_prio_pick.sv
// fixed default-priority encoder for maskable requests
module irq_prio_pick #(
    parameter int N = irq_vec_pkg::NUM_MASKABLE
) (
    // request vector
    input  wire logic [N-1:0] reqVec,
    // result
    output logic              anyReq,
    output logic [4:0]        winIdx
);
    if (N < 1 || N > 32) begin : gBadN
        $error("irq_prio_pick: N out of range");
    end

    always_comb begin
        anyReq = 1'b0;
        winIdx = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (reqVec[i]) begin
                anyReq = 1'b1;
                winIdx = 5'(i);
            end
        end
    end
endmodule : irq_prio_pick

// ===== src/vectored_interrupt_sources.sv
// request collection, arbitration and vectored entry/return sequencing
module vectored_interrupt_sources #(
    parameter int N = irq_vec_pkg::NUM_MASKABLE
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 srst,
    // external pins (asynchronous)
    input  wire logic                 nmiPin,
    input  wire logic [5:0]           extPin,
    input  wire logic [5:0]           pinRiseEn,
    input  wire logic [5:0]           pinFallEn,
    input  wire logic                 nmiRiseSel,
    // internal event pulses
    input  wire logic                 watchdog_overflow_req,
    input  wire logic                 timer0_match_a_req,
    input  wire logic                 timer0_match_b_req,
    input  wire logic                 timer1Match8A,
    input  wire logic                 timer1Match8B,
    input  wire logic                 timer1Match16A,
    input  wire logic                 timer1Match16B,
    input  wire logic                 timer1Wide,
    input  wire logic                 timer2_match_a_req,
    input  wire logic                 timer2_match_b_req,
    input  wire logic                 timer3Match8,
    input  wire logic                 timer3Match16,
    input  wire logic                 timer3Wide,
    input  wire logic                 conversion_done_req,
    input  wire logic                 async0_rx_error_req,
    input  wire logic                 async0_rx_done_req,
    input  wire logic                 clocked1XferDone,
    input  wire logic                 async0_tx_done_req,
    input  wire logic                 clocked_serial_done_req,
    input  wire logic                 async2_rx_error_req,
    input  wire logic                 async2_rx_done_req,
    input  wire logic                 clocked2XferDone,
    input  wire logic                 async2_tx_done_req,
    input  wire logic                 i2c_stop_seen_req,
    // cpu core side
    input  wire logic                 break_trap_instr,
    input  wire logic                 break_ctx_switch_instr,
    input  wire logic                 protWrite,
    input  wire logic [7:0]           protByte,
    input  wire logic [7:0]           protByteInv,
    input  wire logic                 irqEnable,
    input  wire logic [N-1:0]         maskVec,
    input  wire logic                 return_from_irq_instr,
    input  wire logic [19:0]          curPc,
    input  wire logic [15:0]          program_status_word,
    // memory port (vector fetch, stack)
    input  wire logic                 memDone,
    input  wire logic [15:0]          memRdata,
    // outputs, plus the stack pointer input
    output logic                      memRd_ff,
    output logic                      memWr_ff,
    output logic [19:0]               memAddr_ff,
    output logic [19:0]               memWdata_ff,
    output logic                      pcLoad_ff,
    output logic [19:0]               pcValue_ff,
    output logic                      pswLoad_ff,
    output logic [15:0]               pswValue_ff,
    output logic                      busy_ff,
    output logic [N-1:0]              pending_ff,
    output logic                      timer0Trig_ff,
    output logic                      timer1Trig_ff,
    output logic                      timer2Trig_ff,
    input  wire logic [19:0]          stackPtr,
    output logic [19:0]               stackPtrNew_ff,
    output logic                      spLoad_ff
);
    if (N != irq_vec_pkg::NUM_MASKABLE) begin : gBadN
        $error("vectored_interrupt_sources: N must be 22");
    end

    // ------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------
    logic [6:0] pinMeta_ff;
    logic [6:0] pinSync_ff;
    logic [6:0] pinPrev_ff;
    logic [5:0] pinEdge;
    logic       nmiEdge;

    always_ff @(posedge mclk) begin
        if (srst) begin
            pinMeta_ff <= 7'h00;
            pinSync_ff <= 7'h00;
            pinPrev_ff <= 7'h00;
        end else begin
            pinMeta_ff <= {nmiPin, extPin};
            pinSync_ff <= pinMeta_ff;
            pinPrev_ff <= pinSync_ff;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : gEdge
            assign pinEdge[g] = (pinRiseEn[g] & pinSync_ff[g] & ~pinPrev_ff[g])
                              | (pinFallEn[g] & ~pinSync_ff[g] & pinPrev_ff[g]);
        end
    endgenerate

    assign nmiEdge = nmiRiseSel ? (pinSync_ff[6] & ~pinPrev_ff[6])
                                : (~pinSync_ff[6] & pinPrev_ff[6]);

    // pin 0-3 edges double as timer capture/event triggers
    always_ff @(posedge mclk) begin
        if (srst) begin
            timer0Trig_ff <= 1'b0;
            timer1Trig_ff <= 1'b0;
            timer2Trig_ff <= 1'b0;
        end else begin
            timer1Trig_ff <= pinEdge[0];
            timer2Trig_ff <= pinEdge[1] | pinEdge[2];
            timer0Trig_ff <= pinEdge[3];
        end
    end

    // ------------------------------------------------
    // maskable request collection
    // ------------------------------------------------
    logic [N-1:0] rawReq;

    always_comb begin
        rawReq = '0;
        rawReq[irq_vec_pkg::PRI_PIN0]  = pinEdge[0];
        rawReq[irq_vec_pkg::PRI_PIN1]  = pinEdge[1];
        rawReq[irq_vec_pkg::PRI_PIN2]  = pinEdge[2];
        rawReq[irq_vec_pkg::PRI_PIN3]  = pinEdge[3];
        rawReq[irq_vec_pkg::PRI_T0A]   = timer0_match_a_req;
        rawReq[irq_vec_pkg::PRI_T0B]   = timer0_match_b_req;
        rawReq[irq_vec_pkg::PRI_T1A]   = timer1Wide ? timer1Match16A : timer1Match8A;
        rawReq[irq_vec_pkg::PRI_T1B]   = timer1Wide ? timer1Match16B : timer1Match8B;
        rawReq[irq_vec_pkg::PRI_T2A]   = timer2_match_a_req;
        rawReq[irq_vec_pkg::PRI_T2B]   = timer2_match_b_req;
        rawReq[irq_vec_pkg::PRI_T3]    = timer3Wide ? timer3Match16 : timer3Match8;
        rawReq[irq_vec_pkg::PRI_PIN4]  = pinEdge[4];
        rawReq[irq_vec_pkg::PRI_PIN5]  = pinEdge[5];
        rawReq[irq_vec_pkg::PRI_CONV]  = conversion_done_req;
        rawReq[irq_vec_pkg::PRI_A0ERR] = async0_rx_error_req;
        rawReq[irq_vec_pkg::PRI_A0RX]  = async0_rx_done_req | clocked1XferDone;
        rawReq[irq_vec_pkg::PRI_A0TX]  = async0_tx_done_req;
        rawReq[irq_vec_pkg::PRI_CSI]   = clocked_serial_done_req;
        rawReq[irq_vec_pkg::PRI_A2ERR] = async2_rx_error_req;
        rawReq[irq_vec_pkg::PRI_A2RX]  = async2_rx_done_req | clocked2XferDone;
        rawReq[irq_vec_pkg::PRI_A2TX]  = async2_tx_done_req;
        rawReq[irq_vec_pkg::PRI_I2C]   = i2c_stop_seen_req;
    end

    // ------------------------------------------------
    // pending flags: a new event wins over its acknowledge
    // ------------------------------------------------
    logic         nmiPend_ff;
    logic         wdtPend_ff;
    logic         operrPend_ff;
    logic         brkPend_ff;
    logic [N-1:0] ackVec;
    logic         ackNmi;
    logic         ackWdt;
    logic         ackOperr;
    logic         ackBrk;
    logic         operandBad;

    // complement check: byte xor its inverse must be all ones
    assign operandBad = protWrite && ((protByte ^ protByteInv) != irq_vec_pkg::OPERAND_OK);

    always_ff @(posedge mclk) begin
        if (srst) begin
            pending_ff <= '0;
        end else begin
            pending_ff <= (pending_ff & ~ackVec) | rawReq;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            nmiPend_ff   <= 1'b0;
            wdtPend_ff   <= 1'b0;
            operrPend_ff <= 1'b0;
            brkPend_ff   <= 1'b0;
        end else begin
            nmiPend_ff   <= (nmiPend_ff & ~ackNmi) | nmiEdge;
            wdtPend_ff   <= (wdtPend_ff & ~ackWdt) | watchdog_overflow_req;
            operrPend_ff <= (operrPend_ff & ~ackOperr) | operandBad;
            brkPend_ff   <= (brkPend_ff & ~ackBrk)
                          | break_trap_instr | break_ctx_switch_instr;
        end
    end

    // ------------------------------------------------
    // arbitration
    // ------------------------------------------------
    logic         anyMask;
    logic [4:0]   maskIdx;
    logic [N-1:0] eligible;

    assign eligible = pending_ff & ~maskVec;

    irq_prio_pick #(.N(N)) uPick (
        .reqVec (eligible),
        .anyReq (anyMask),
        .winIdx (maskIdx)
    );

    function automatic logic [15:0] maskVector(input logic [4:0] idx);
        maskVector = irq_vec_pkg::VEC_MASK_BASE
                   + 16'(idx) * irq_vec_pkg::VEC_STEP;
    endfunction : maskVector

    // ------------------------------------------------
    // entry / return sequencer
    // ------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH_PC,
        ST_PUSH_PSW,
        ST_FETCH,
        ST_POP_PSW,
        ST_POP_PC
    } seq_t;

    seq_t        state_ff;
    logic [15:0] vecAddr_ff;

    logic        take;
    logic [15:0] takeVec;
    always_comb begin
        take     = 1'b0;
        takeVec  = 16'h0000;
        ackVec   = '0;
        ackNmi   = 1'b0;
        ackWdt   = 1'b0;
        ackOperr = 1'b0;
        ackBrk   = 1'b0;
        if (state_ff == ST_IDLE && !return_from_irq_instr) begin
            if (brkPend_ff) begin
                take = 1'b1; ackBrk = 1'b1; takeVec = irq_vec_pkg::VEC_BREAK;
            end else if (operrPend_ff) begin
                take = 1'b1; ackOperr = 1'b1; takeVec = irq_vec_pkg::VEC_OPERR;
            end else if (nmiPend_ff) begin
                take = 1'b1; ackNmi = 1'b1; takeVec = irq_vec_pkg::VEC_PIN_NMI;
            end else if (wdtPend_ff) begin
                take = 1'b1; ackWdt = 1'b1; takeVec = irq_vec_pkg::VEC_WATCHDOG;
            end else if (irqEnable && anyMask) begin
                take = 1'b1;
                ackVec[maskIdx] = 1'b1;
                takeVec = maskVector(maskIdx);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff   <= ST_IDLE;
            vecAddr_ff <= 16'h0000;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (return_from_irq_instr) begin
                        state_ff <= ST_POP_PSW;
                    end else if (take) begin
                        state_ff   <= ST_PUSH_PC;
                        vecAddr_ff <= takeVec;
                    end
                end
                ST_PUSH_PC:  if (memDone) state_ff <= ST_PUSH_PSW;
                ST_PUSH_PSW: if (memDone) state_ff <= ST_FETCH;
                ST_FETCH:    if (memDone) state_ff <= ST_IDLE;
                ST_POP_PSW:  if (memDone) state_ff <= ST_POP_PC;
                ST_POP_PC:   if (memDone) state_ff <= ST_IDLE;
                default:     state_ff <= ST_IDLE;
            endcase
        end
    end

    // memory strobes held while a step waits for memDone
    always_ff @(posedge mclk) begin
        if (srst) begin
            memRd_ff       <= 1'b0;
            memWr_ff       <= 1'b0;
            memAddr_ff     <= 20'h00000;
            memWdata_ff    <= 20'h00000;
            stackPtrNew_ff <= 20'h00000;
            spLoad_ff      <= 1'b0;
            busy_ff        <= 1'b0;
        end else begin
            spLoad_ff <= 1'b0;
            memRd_ff  <= 1'b0;
            memWr_ff  <= 1'b0;
            busy_ff   <= (state_ff != ST_IDLE) || take || return_from_irq_instr;
            case (state_ff)
                ST_IDLE: begin
                    if (return_from_irq_instr) begin
                        memRd_ff   <= 1'b1;
                        memAddr_ff <= stackPtr;
                    end else if (take) begin
                        memWr_ff    <= 1'b1;
                        memAddr_ff  <= stackPtr - 20'h00001;
                        memWdata_ff <= curPc;
                    end
                end
                ST_PUSH_PC: begin
                    if (memDone) begin
                        memWr_ff    <= 1'b1;
                        memAddr_ff  <= stackPtr - 20'h00002;
                        memWdata_ff <= {4'h0, program_status_word};
                    end else begin
                        memWr_ff <= 1'b1;
                    end
                end
                ST_PUSH_PSW: begin
                    if (memDone) begin
                        stackPtrNew_ff <= stackPtr - 20'h00002;
                        spLoad_ff      <= 1'b1;
                        memRd_ff       <= 1'b1;
                        memAddr_ff     <= {irq_vec_pkg::PC_TOP_CLEAR, vecAddr_ff};
                    end else begin
                        memWr_ff <= 1'b1;
                    end
                end
                ST_POP_PSW: begin
                    memRd_ff <= 1'b1;
                    if (memDone) memAddr_ff <= stackPtr + 20'h00001;
                end
                ST_POP_PC: begin
                    if (memDone) begin
                        stackPtrNew_ff <= stackPtr + 20'h00002;
                        spLoad_ff      <= 1'b1;
                    end else begin
                        memRd_ff <= 1'b1;
                    end
                end
                ST_FETCH: begin
                    if (!memDone) memRd_ff <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // program counter and status word loads
    always_ff @(posedge mclk) begin
        if (srst) begin
            pcLoad_ff   <= 1'b0;
            pcValue_ff  <= 20'h00000;
            pswLoad_ff  <= 1'b0;
            pswValue_ff <= 16'h0000;
        end else begin
            pcLoad_ff  <= 1'b0;
            pswLoad_ff <= 1'b0;
            if (state_ff == ST_FETCH && memDone) begin
                pcLoad_ff  <= 1'b1;
                pcValue_ff <= {irq_vec_pkg::PC_TOP_CLEAR, memRdata};
            end else if (state_ff == ST_POP_PSW && memDone) begin
                pswLoad_ff  <= 1'b1;
                pswValue_ff <= memRdata;
            end else if (state_ff == ST_POP_PC && memDone) begin
                pcLoad_ff  <= 1'b1;
                pcValue_ff <= {irq_vec_pkg::PC_TOP_CLEAR, memRdata};
            end
        end
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    a_nmi_beats_mask: assert property (@(posedge mclk) disable iff (srst)
        (state_ff == ST_IDLE && nmiPend_ff && !brkPend_ff && !operrPend_ff
         && !return_from_irq_instr) |=> vecAddr_ff == irq_vec_pkg::VEC_PIN_NMI)
        else $error("nmi lost to a lower source");
    a_pc_top_clear: assert property (@(posedge mclk) disable iff (srst)
        pcLoad_ff |-> pcValue_ff[19:16] == irq_vec_pkg::PC_TOP_CLEAR)
        else $error("branch target above 16 bits");
    a_fetch_loads_pc: assert property (@(posedge mclk) disable iff (srst)
        (state_ff == ST_FETCH && memDone) |=> pcLoad_ff && pcValue_ff[15:0] == $past(memRdata))
        else $error("vector not loaded into pc");
    a_push_pc_first: assert property (@(posedge mclk) disable iff (srst)
        (state_ff == ST_IDLE && take && !return_from_irq_instr)
        |=> memWr_ff && memWdata_ff == $past(curPc))
        else $error("pc not pushed on entry");
    a_return_from_irq_instr_pops: assert property (@(posedge mclk) disable iff (srst)
        (state_ff == ST_IDLE && return_from_irq_instr) |=> state_ff == ST_POP_PSW ##0 memRd_ff)
        else $error("return did not start pop");
    a_low_idx_wins: assert property (@(posedge mclk) disable iff (srst)
        anyMask |-> (eligible & ((N'(1) << maskIdx) - N'(1))) == '0)
        else $error("lower default priority not chosen");
    a_operr_sets: assert property (@(posedge mclk) disable iff (srst)
        operandBad |=> operrPend_ff || vecAddr_ff == irq_vec_pkg::VEC_OPERR)
        else $error("operand error not raised");
    a_pin0_timer1: assert property (@(posedge mclk) disable iff (srst)
        pinEdge[0] |=> timer1Trig_ff && pending_ff[irq_vec_pkg::PRI_PIN0])
        else $error("pin0 edge not routed");
endmodule : vectored_interrupt_sources

// ===== verif/mem_model.sv
// memory partner: vector table words and stack storage
module mem_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // block requests
    input  wire logic        memRd_ff,
    input  wire logic        memWr_ff,
    input  wire logic [19:0] memAddr_ff,
    input  wire logic [19:0] memWdata_ff,
    input  wire logic        slow,
    // answer
    output logic             memDone,
    output logic [15:0]      memRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [int];
    logic [15:0] lastD = 16'h0000;
    int          cnt = 0;
    initial memDone = 1'b0;
    // data shows the inverse until memDone so a stale word never passes
    assign memRdata = memDone ? lastD : ~lastD;
    always @(posedge mclk) begin
        memDone <= 1'b0;
        cnt <= 0;
        if (!srst && !memDone && (memRd_ff || memWr_ff)) begin
            cnt <= cnt + 1;
            if (cnt >= (slow ? 3 : 0)) begin
                memDone <= 1'b1;
                if (memWr_ff)
                    mem[int'(memAddr_ff)] = memWdata_ff[15:0];
                else
                    lastD <= mem.exists(int'(memAddr_ff)) ? mem[int'(memAddr_ff)]
                                                          : memAddr_ff[15:0] ^ 16'hC3C3;
            end
        end
    end
endmodule : mem_model

// ===== verif/vectored_interrupt_sources_tb.sv
// self-checking bench for the vectored interrupt block
module vectored_interrupt_sources_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, srst = 1'b1, irqEnable = 1'b1, wide = 1'b1, slow = 1'b0;
    logic        protWrite = 1'b0, return_from_irq_instr = 1'b0;
    logic [5:0]  extPin = 6'h00;
    logic [8:0]  ev = 9'h000;
    logic [7:0]  protByte = 8'h5A, protByteInv = 8'hA5;
    logic [21:0] pv = 22'h0, maskVec = 22'h0, pending_ff;
    logic [19:0] curPc = 20'hA1234, stackPtr = 20'h00400, spSeen;
    logic [15:0] program_status_word = 16'hBEEF, pswValue_ff, memRdata, pswSeen;
    logic        memRd_ff, memWr_ff, pcLoad_ff, pswLoad_ff, busy_ff, spLoad_ff, memDone;
    logic [19:0] memAddr_ff, memWdata_ff, pcValue_ff, stackPtrNew_ff;
    logic [2:0]  tr, tg = 3'b000;
    logic [19:0] wq[$], rq[$];
    int          bad_count = 0, n_compared = 0;
    always #12.5 mclk = ~mclk;
    vectored_interrupt_sources i_dut (
        .mclk, .srst, .nmiPin(ev[8]), .extPin, .pinRiseEn(6'h3F), .pinFallEn(6'h00),
        .nmiRiseSel(1'b1), .watchdog_overflow_req(ev[7]), .timer0_match_a_req(pv[4]),
        .timer0_match_b_req(pv[5]), .timer1Match8A(ev[2]), .timer1Match8B(ev[3]),
        .timer1Match16A(pv[6]), .timer1Match16B(pv[7]), .timer1Wide(wide),
        .timer2_match_a_req(pv[8]), .timer2_match_b_req(pv[9]), .timer3Match8(ev[4]),
        .timer3Match16(pv[10]), .timer3Wide(wide), .conversion_done_req(pv[13]),
        .async0_rx_error_req(pv[14]), .async0_rx_done_req(pv[15]), .clocked1XferDone(ev[0]),
        .async0_tx_done_req(pv[16]), .clocked_serial_done_req(pv[17]),
        .async2_rx_error_req(pv[18]), .async2_rx_done_req(pv[19]), .clocked2XferDone(ev[1]),
        .async2_tx_done_req(pv[20]), .i2c_stop_seen_req(pv[21]), .break_trap_instr(ev[5]),
        .break_ctx_switch_instr(ev[6]), .protWrite, .protByte, .protByteInv, .irqEnable,
        .maskVec, .return_from_irq_instr, .curPc, .program_status_word, .memDone, .memRdata,
        .memRd_ff, .memWr_ff, .memAddr_ff, .memWdata_ff, .pcLoad_ff, .pcValue_ff, .pswLoad_ff,
        .pswValue_ff, .busy_ff, .pending_ff, .timer0Trig_ff(tr[0]), .timer1Trig_ff(tr[1]),
        .timer2Trig_ff(tr[2]), .stackPtr, .stackPtrNew_ff, .spLoad_ff);
    mem_model i_mem (.mclk, .srst, .memRd_ff, .memWr_ff, .memAddr_ff, .memWdata_ff, .slow,
        .memDone, .memRdata);
    // ----
    // monitors and shared tasks
    // ----
    always @(posedge mclk) begin
        if (memDone && memWr_ff) wq.push_back(memAddr_ff);
        if (memDone && memWr_ff) wq.push_back(memWdata_ff);
        if (memDone && memRd_ff) rq.push_back(memAddr_ff);
        if (pswLoad_ff) pswSeen = pswValue_ff;
        if (spLoad_ff) spSeen = stackPtrNew_ff;
        tg = tg | tr;
    end
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic pulse(input logic [21:0] p, input logic [8:0] e, input logic [5:0] x);
        @(negedge mclk);
        {pv, ev, extPin} = {p, e, x};
        @(negedge mclk);
        {pv, ev, extPin} = '0;
    endtask : pulse
    task automatic waitFor;
        int i;
        for (i = 0; i < 300 && pcLoad_ff !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (i >= 300) chk("pc load wait", 20'h00001, 20'h00000);
    endtask : waitFor
    task automatic enter(input logic [15:0] vec);
        waitFor;
        chk("branch target", {4'h0, vec ^ 16'hC3C3}, pcValue_ff);
        chk("vector fetch", {4'h0, vec}, rq[0]);
        chk("pc push", stackPtr - 20'h00001, wq[0]);
        chk("pc data", curPc, wq[1]);
        chk("psw push", stackPtr - 20'h00002, wq[2]);
        chk("psw data", {4'h0, program_status_word}, wq[3]);
        chk("new sp", stackPtr - 20'h00002, spSeen);
        // a queued source may enter at once, so busy need not drop
        @(posedge mclk);
        #1;
        wq.delete();
        rq.delete();
    endtask : enter
    // ----
    // scenarios
    // ----
    task automatic t_vectors;
        for (int k = 0; k < 24; k++) begin
            logic [5:0] x;
            x = (k < 4) ? 6'h01 << k : (k == 11) ? 6'h10 : (k == 12) ? 6'h20 : 6'h00;
            slow = k[0];
            tg = 3'b000;
            if (k > 21)
                pulse(22'h0, 9'h001 << (k - 22), 6'h00);
            else
                pulse((x != 6'h00) ? 22'h0 : 22'h000001 << k, 9'h000, x);
            enter(k == 22 ? 16'h0024 : k == 23 ? 16'h002C : 16'h0006 + 16'(2 * k));
            chk("trigger", k == 0 ? 20'h2 : (k == 1 || k == 2) ? 20'h4 : k == 3 ? 20'h1 : 20'h0,
                {17'h0, tg});
        end
        $display("vector table test done");
    endtask : t_vectors
    task automatic t_soft;
        pulse(22'h0, 9'h020, 6'h00);
        enter(16'h003E);
        pulse(22'h0, 9'h040, 6'h00);
        enter(16'h003E);
        pulse(22'h0, 9'h100, 6'h00);
        enter(16'h0002);
        pulse(22'h0, 9'h080, 6'h00);
        enter(16'h0004);
        for (int j = 0; j < 2; j++) begin
            @(negedge mclk);
            protByteInv = j ? 8'hA4 : 8'hA5;
            protWrite = 1'b1;
            @(negedge mclk);
            protWrite = 1'b0;
            repeat (8) @(negedge mclk);
            chk("operand trap", {19'h0, j[0]}, {19'h0, busy_ff});
        end
        enter(16'h003C);
        $display("software and nonmaskable test done");
    endtask : t_soft
    task automatic t_order;
        pulse(22'h002100, 9'h080, 6'h00);
        enter(16'h0004);
        enter(16'h0016);
        enter(16'h0020);
        @(negedge mclk);
        irqEnable = 1'b0;
        pulse(22'h000020, 9'h000, 6'h00);
        repeat (8) @(negedge mclk);
        chk("held request", 20'h00020, {busy_ff, pending_ff[18:0]});
        pulse(22'h0, 9'h100, 6'h00);
        enter(16'h0002);
        @(negedge mclk);
        {irqEnable, maskVec} = {1'b1, 22'h000020};
        repeat (8) @(negedge mclk);
        chk("masked request", 20'h00020, {busy_ff, pending_ff[18:0]});
        maskVec = 22'h0;
        enter(16'h0010);
        $display("priority test done");
    endtask : t_order
    task automatic t_mode;
        @(negedge mclk);
        wide = 1'b0;
        pulse(22'h0, 9'h010, 6'h00);
        enter(16'h001A);
        pulse(22'h0, 9'h008, 6'h00);
        enter(16'h0014);
        pulse(22'h000040, 9'h000, 6'h00);
        repeat (8) @(negedge mclk);
        chk("wide match in narrow mode", 20'h0, {busy_ff, pending_ff[18:0]});
        $display("counter mode test done");
    endtask : t_mode
    task automatic t_return;
        @(negedge mclk);
        stackPtr = 20'h003FE;
        return_from_irq_instr = 1'b1;
        @(negedge mclk);
        return_from_irq_instr = 1'b0;
        waitFor;
        chk("resumed pc", {4'h0, curPc[15:0]}, pcValue_ff);
        chk("restored psw", {4'h0, program_status_word}, {4'h0, pswSeen});
        chk("sp load", 20'h00001, {19'h0, spLoad_ff});
        chk("stack pointer", 20'h00400, stackPtrNew_ff);
        $display("return test done");
    endtask : t_return
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        repeat (3) @(negedge mclk);
        srst = 1'b0;
        t_vectors;
        t_soft;
        t_order;
        t_mode;
        t_return;
        conclude;
    end
    initial begin
        #500us;
        bad_count++;
        conclude;
    end
endmodule : vectored_interrupt_sources_tb
